/* File: shared/lead_pkg.sv */
// Constants and carrier types for the terminal lead supervisor.
// Assumes a 100 MHz system clock and a classic Wishbone register slave.
package lead_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned RATE_W = 3;
	localparam int unsigned NUM_RATES = 8;
	localparam int unsigned CNT_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;

	// Control field positions
	localparam int unsigned CTRL_ANTI_EN = 0;
	localparam int unsigned CTRL_EXT_DLY = 1;
	localparam int unsigned CTRL_RATE_LO = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Status word field positions
	localparam int unsigned STAT_STATE_LO = 0;
	localparam int unsigned STAT_CTS = 2;
	localparam int unsigned STAT_RTS = 3;

	// Event bit positions
	localparam int unsigned EV_TIMEOUT = 0;
	localparam int unsigned EV_LINE_ERR = 1;
	localparam int unsigned EV_PAT_ERR = 2;
	localparam int unsigned EV_NO_SIG = 3;
	localparam int unsigned EV_OOS = 4;
	localparam int unsigned EV_W = 5;

	// Indicator flash stretch
	localparam int unsigned FLASH_NS = 50_000_000;
	localparam int unsigned FLASH_CYC = FLASH_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned EXT_FACTOR = 4;

	// Line rates in bit/s: 2.4, 4.8, 9.6, 19.2, 38.4, 56, 64, 72 kbps
	localparam int unsigned RATE_BPS [NUM_RATES] = '{2400, 4800, 9600, 19200, 38400, 56000, 64000, 72000};
	// Anti-streaming budget and normal delay in line bit times
	localparam int unsigned STREAM_BITS = 65536;
	localparam int unsigned DELAY_BITS = 32;

	typedef enum logic [1:0] {
		RTS_IDLE = 2'b00,
		RTS_WAIT = 2'b01,
		RTS_CLEAR = 2'b11,
		RTS_LOCK = 2'b10
	} rts_state_e;

	typedef struct packed {
		logic rts;
		logic dtr;
		logic txd;
		logic rxd;
		logic carrier;
		logic no_signal;
		logic oos;
		logic line_err;
		logic pat_err;
		logic test_local;
		logic test_remote;
		logic test_provider;
		logic pattern_on;
	} lead_in_s;

	typedef struct packed {
		logic cts;
		logic txd_ind;
		logic rxd_ind;
		logic cts_ind;
		logic carrier_indicator;
		logic dtr_ind;
		logic no_signal_indicator;
		logic out_of_service_indicator;
		logic receive_error_indicator;
		logic test_active_indicator;
	} lead_out_s;
endpackage

/* File: hw/lead_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes the pins are quasi-static or unrelated to i_clk.
`timescale 1ns/10ps
`default_nettype none
module lead_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_state_s;

	sync_state_s st;
	sync_state_s next_st;

	always_comb begin
		next_st = st;
		next_st.meta = i_async;
		next_st.sync = st.meta;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.sync;
endmodule
`default_nettype wire

/* File: hw/dte_lead_supervisor.sv */
// Terminal lead supervisor: request/clear handshake, anti-streaming, indicators.
// Assumes lead inputs are asynchronous pins and registers sit on classic Wishbone.
//
// What this block does
// RL1: Streaming request past timeout is treated off.
// RL2: Forced off until terminal drops request.
// RL3: Timeout shortens at higher line rates.
// RL4: Anti-streaming selectable, disabled after reset.
// RL5: Turn-on delay normal or extended, normal default.
// RL6: Extended delay is four times normal.
// RL7: Turn-on delay shrinks as line rate rises.
// RL8: Clear-to-send only when ready for data.
// RL9: Data indicators follow each data lead bit.
// RL10: Carrier indicator on while carrier valid.
// RL11: Terminal-ready indicator follows terminal-ready lead.
// RL12: No-signal indicator lit without line signal.
// RL13: Out-of-service indicator lit during service code.
// RL14: Error indicator pulses on violations, framing errors.
// RL15: During pattern test, pulses on bit errors.
// RL16: Test indicator lit for any test source.
// RL17: Clear-to-send held off while request forced.
// RL18: Lengths come from per-rate cycle-count table.
`timescale 1ns/10ps
`default_nettype none
module dte_lead_supervisor #(
	parameter int unsigned FLASH_CYCLES = lead_pkg::FLASH_CYC,
	parameter int unsigned STREAM_SCALE = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire lead_pkg::lead_in_s i_leads,
	output lead_pkg::lead_out_s o_leads,
	output logic o_irq
);
	localparam int unsigned LEADS_W = $bits(lead_pkg::lead_in_s);

	// Per-rate cycle counts; budget is divided by STREAM_SCALE so simulation can shorten it
	function automatic logic [lead_pkg::CNT_W-1:0] stream_cycles(input logic [lead_pkg::RATE_W-1:0] rate);
		longint unsigned c;
		c = (longint'(lead_pkg::STREAM_BITS) * lead_pkg::CLK_HZ) / lead_pkg::RATE_BPS[rate] / STREAM_SCALE;
		if (c == 0) begin
			c = 1;
		end
		return lead_pkg::CNT_W'(c);
	endfunction

	function automatic logic [lead_pkg::CNT_W-1:0] delay_cycles(input logic [lead_pkg::RATE_W-1:0] rate,
		input logic extended);
		longint unsigned c;
		c = (longint'(lead_pkg::DELAY_BITS) * lead_pkg::CLK_HZ + lead_pkg::RATE_BPS[rate] - 1)
			/ lead_pkg::RATE_BPS[rate];
		if (extended) begin
			c = c * lead_pkg::EXT_FACTOR; // see RL6
		end
		return lead_pkg::CNT_W'(c);
	endfunction

	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
		return adr == off;
	endfunction

	typedef struct packed {
		logic anti_en;
		logic ext_dly;
		logic [lead_pkg::RATE_W-1:0] rate;
		lead_pkg::rts_state_e rts_st;
		logic [lead_pkg::CNT_W-1:0] dly_cnt;
		logic [lead_pkg::CNT_W-1:0] stream_cnt;
		logic [lead_pkg::CNT_W-1:0] flash_cnt;
		logic [lead_pkg::EV_W-1:0] irq_stat;
		logic [lead_pkg::EV_W-1:0] irq_mask;
		logic prev_no_sig;
		logic prev_oos;
		logic ack;
		logic [31:0] rdat;
		lead_pkg::lead_out_s outs;
	} sup_state_s;

	sup_state_s st;
	sup_state_s next_st;
	lead_pkg::lead_in_s lin;

	// Constant per-rate tables, so no divider sits in the rate path
	logic [lead_pkg::CNT_W-1:0] stream_tab [lead_pkg::NUM_RATES];
	logic [lead_pkg::CNT_W-1:0] norm_tab [lead_pkg::NUM_RATES];
	logic [lead_pkg::CNT_W-1:0] ext_tab [lead_pkg::NUM_RATES];

	for (genvar g = 0; g < lead_pkg::NUM_RATES; g++) begin : g_rate
		assign stream_tab[g] = stream_cycles(lead_pkg::RATE_W'(g)); // see RL3, RL18
		assign norm_tab[g] = delay_cycles(lead_pkg::RATE_W'(g), 1'b0); // see RL7, RL18
		assign ext_tab[g] = delay_cycles(lead_pkg::RATE_W'(g), 1'b1); // see RL6
	end

	lead_sync #(
		.WIDTH(LEADS_W)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_leads),
		.o_sync(lin)
	);

	always_comb begin
		logic req;
		logic wr;
		logic timeout;
		logic err_event;
		logic [lead_pkg::EV_W-1:0] events;
		logic [31:0] ctrl_rd;
		logic [31:0] stat_rd;
		logic [lead_pkg::CNT_W-1:0] dly_lim;
		logic [lead_pkg::CNT_W-1:0] stream_lim;
		req = 1'b0;
		wr = 1'b0;
		timeout = 1'b0;
		err_event = 1'b0;
		events = '0;
		ctrl_rd = '0;
		stat_rd = '0;
		dly_lim = '0;
		stream_lim = '0;
		next_st = st;

		// Rate or delay change acts on a running count at once; counts are not rescaled
		dly_lim = st.ext_dly ? ext_tab[st.rate] : norm_tab[st.rate]; // see RL5
		stream_lim = stream_tab[st.rate];

		// Wishbone classic: ack one cycle after request, dropped the next
		// No wait states; a request held into the ack cycle is ignored, so back-to-back requests are taken only every other cycle
		req = i_wb_cyc && i_wb_stb && !st.ack;
		wr = req && i_wb_we;
		next_st.ack = req;

		ctrl_rd[lead_pkg::CTRL_ANTI_EN] = st.anti_en;
		ctrl_rd[lead_pkg::CTRL_EXT_DLY] = st.ext_dly;
		ctrl_rd[lead_pkg::CTRL_RATE_LO +: lead_pkg::RATE_W] = st.rate;
		stat_rd[lead_pkg::STAT_STATE_LO +: $bits(lead_pkg::rts_state_e)] = st.rts_st;
		stat_rd[lead_pkg::STAT_CTS] = st.outs.cts;
		stat_rd[lead_pkg::STAT_RTS] = lin.rts;

		if (wr && i_wb_sel[0]) begin
			if (reg_hit(i_wb_adr, lead_pkg::OFF_CTRL)) begin
				next_st.anti_en = i_wb_dat[lead_pkg::CTRL_ANTI_EN]; // see RL4
				next_st.ext_dly = i_wb_dat[lead_pkg::CTRL_EXT_DLY]; // see RL5
				next_st.rate = i_wb_dat[lead_pkg::CTRL_RATE_LO +: lead_pkg::RATE_W];
			end
			if (reg_hit(i_wb_adr, lead_pkg::OFF_IRQ_MASK)) begin
				next_st.irq_mask = i_wb_dat[lead_pkg::EV_W-1:0];
			end
		end
		if (req) begin
			unique case (1'b1)
				reg_hit(i_wb_adr, lead_pkg::OFF_CTRL): next_st.rdat = ctrl_rd;
				reg_hit(i_wb_adr, lead_pkg::OFF_STAT): next_st.rdat = stat_rd;
				reg_hit(i_wb_adr, lead_pkg::OFF_IRQ_STAT): next_st.rdat = 32'(st.irq_stat);
				reg_hit(i_wb_adr, lead_pkg::OFF_IRQ_MASK): next_st.rdat = 32'(st.irq_mask);
				default: next_st.rdat = 32'h0000_0000;
			endcase
		end

		// Request/clear sequence; counts come from the rate table
		unique case (st.rts_st)
			lead_pkg::RTS_IDLE: begin
				next_st.stream_cnt = '0;
				next_st.dly_cnt = '0;
				if (lin.rts) begin
					next_st.rts_st = lead_pkg::RTS_WAIT;
				end
			end
			lead_pkg::RTS_WAIT: begin
				next_st.dly_cnt = st.dly_cnt + 1'b1;
				next_st.stream_cnt = st.stream_cnt + 1'b1;
				if (!lin.rts) begin
					next_st.rts_st = lead_pkg::RTS_IDLE;
				end else if (st.dly_cnt + 1'b1 >= dly_lim) begin // see RL5, RL7, RL18
					next_st.rts_st = lead_pkg::RTS_CLEAR;
				end
			end
			lead_pkg::RTS_CLEAR: begin
				next_st.stream_cnt = st.stream_cnt + 1'b1;
				if (!lin.rts) begin
					next_st.rts_st = lead_pkg::RTS_IDLE;
				end
			end
			// Lock ignores the rate; only a dropped lead re-arms
			lead_pkg::RTS_LOCK: begin
				if (!lin.rts) begin
					next_st.rts_st = lead_pkg::RTS_IDLE; // see RL2
				end
			end
			default: next_st.rts_st = lead_pkg::RTS_IDLE;
		endcase
		// Timer counts the whole assertion, turn-on delay included
		if (st.anti_en && lin.rts && st.rts_st != lead_pkg::RTS_LOCK && st.rts_st != lead_pkg::RTS_IDLE
			&& st.stream_cnt + 1'b1 >= stream_lim) begin // see RL1, RL3, RL18
			timeout = 1'b1;
			next_st.rts_st = lead_pkg::RTS_LOCK;
		end

		// Clear only in the clear state, never while locked
		next_st.outs.cts = next_st.rts_st == lead_pkg::RTS_CLEAR; // see RL8, RL17
		next_st.outs.cts_ind = next_st.outs.cts;

		next_st.outs.txd_ind = lin.txd; // see RL9
		next_st.outs.rxd_ind = lin.rxd; // see RL9
		next_st.outs.carrier_indicator = lin.carrier; // see RL10
		next_st.outs.dtr_ind = lin.dtr; // see RL11
		next_st.outs.no_signal_indicator = lin.no_signal; // see RL12
		next_st.outs.out_of_service_indicator = lin.oos; // see RL13
		next_st.outs.test_active_indicator = lin.test_local | lin.test_remote | lin.test_provider
			| lin.pattern_on; // see RL16

		// Error flash stretched so a single error is visible; retriggers
		err_event = lin.line_err || (lin.pattern_on && lin.pat_err); // see RL14, RL15
		if (err_event) begin
			next_st.flash_cnt = lead_pkg::CNT_W'(FLASH_CYCLES);
		end else if (st.flash_cnt != '0) begin
			next_st.flash_cnt = st.flash_cnt - 1'b1;
		end
		next_st.outs.receive_error_indicator = err_event || st.flash_cnt != '0;

		// No-signal and out-of-service levels raise edge events, so a stuck line sets its flag once
		events[lead_pkg::EV_TIMEOUT] = timeout;
		events[lead_pkg::EV_LINE_ERR] = lin.line_err;
		events[lead_pkg::EV_PAT_ERR] = lin.pattern_on && lin.pat_err;
		events[lead_pkg::EV_NO_SIG] = lin.no_signal && !st.prev_no_sig;
		events[lead_pkg::EV_OOS] = lin.oos && !st.prev_oos;
		next_st.prev_no_sig = lin.no_signal;
		next_st.prev_oos = lin.oos;

		// Write-one-to-clear; a coincident event wins
		if (wr && i_wb_sel[0] && reg_hit(i_wb_adr, lead_pkg::OFF_IRQ_STAT)) begin
			next_st.irq_stat = st.irq_stat & ~i_wb_dat[lead_pkg::EV_W-1:0];
		end
		next_st.irq_stat = next_st.irq_stat | events;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_wb_ack = st.ack;
	assign o_wb_dat = st.rdat;
	assign o_leads = st.outs;
	assign o_irq = |(st.irq_stat & st.irq_mask);
endmodule
`default_nettype wire

/* File: dv/lead_sva.sv */
// Port checker for the lead supervisor.
// Bound onto every supervisor; sees only its lead ports.
`timescale 1ns/10ps
`default_nettype none
module lead_sva #(
	parameter int unsigned FLASH_CYCLES = 4,
	parameter int unsigned STREAM_SCALE = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire lead_pkg::lead_in_s i_leads,
	input wire lead_pkg::lead_out_s o_leads
);
	logic [2:0] up;
	logic [2:0] run;
	wire logic any_test = i_leads.test_local | i_leads.test_remote | i_leads.test_provider | i_leads.pattern_on;
	// Skip pipeline fill after reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			up <= 3'h0;
			run <= 3'h0;
		end else begin
			up <= (up == 3'h7) ? up : up + 3'h1;
			run <= !i_leads.rts ? 3'h0 : (run == 3'h7) ? run : run + 3'h1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_data_follow: assert property (up > 3'h4 |-> {o_leads.txd_ind, o_leads.rxd_ind} == $past({i_leads.txd, i_leads.rxd}, 3))
		else $error("data indicators lag");
	a_carrier_shown: assert property (up > 3'h4 |-> o_leads.carrier_indicator == $past(i_leads.carrier, 3))
		else $error("carrier indicator wrong");
	a_ready_shown: assert property (up > 3'h4 |-> o_leads.dtr_ind == $past(i_leads.dtr, 3))
		else $error("ready indicator wrong");
	a_nosig_shown: assert property (up > 3'h4 |-> o_leads.no_signal_indicator == $past(i_leads.no_signal, 3))
		else $error("no signal indicator wrong");
	a_oos_shown: assert property (up > 3'h4 |-> o_leads.out_of_service_indicator == $past(i_leads.oos, 3))
		else $error("service indicator wrong");
	a_test_shown: assert property (up > 3'h4 |-> o_leads.test_active_indicator == $past(any_test, 3))
		else $error("test indicator wrong");
	a_err_flash: assert property (up > 3'h4 && $past(i_leads.line_err, 3) |-> o_leads.receive_error_indicator)
		else $error("error indicator missed");
	a_cts_off: assert property (!i_leads.rts [*4] |=> !o_leads.cts)
		else $error("clear without request");
	a_lock_holds: assert property ($fell(o_leads.cts) && run == 3'h7 |-> !o_leads.cts [*6])
		else $error("clear during lock");
	c_cts_up: cover property (o_leads.cts);
	c_lock: cover property ($fell(o_leads.cts) && run == 3'h7);
	c_err: cover property (o_leads.receive_error_indicator);
endmodule
bind dte_lead_supervisor lead_sva #(.FLASH_CYCLES(FLASH_CYCLES), .STREAM_SCALE(STREAM_SCALE)) sva_i (
	.i_clk(i_clk), .i_rst(i_rst), .i_leads(i_leads), .o_leads(o_leads));
`default_nettype wire

/* File: dv/dte_term.sv */
// Terminal model: raises its request on command, sends marks when idle.
// Assumes the bench drives i_send just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module dte_term (
	input wire logic i_clk,
	input wire logic i_send,
	input wire logic i_cts,
	output logic o_rts,
	output logic o_txd
);
	initial begin
		o_rts = 1'b0;
		o_txd = 1'b1;
	end
	// Toggling data only once cleared, so idle marks never look like traffic
	always @(posedge i_clk) begin
		o_rts <= i_send;
		o_txd <= (i_send && i_cts) ? ~o_txd : 1'b1;
	end
endmodule
`default_nettype wire

/* File: dv/dte_lead_supervisor_bench.sv */
// Self-checking bench for the lead supervisor.
// Assumes lead_pkg, the design, the checker and dte_term are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dte_lead_supervisor_bench;
	localparam int unsigned SC = 2000;
	localparam longint R = lead_pkg::RATE_BPS[7];
	localparam longint D = (lead_pkg::DELAY_BITS * longint'(lead_pkg::CLK_HZ) + R - 1) / R;
	localparam longint S = lead_pkg::STREAM_BITS * longint'(lead_pkg::CLK_HZ) / R / SC;
	logic clk, rst, cyc, stb, we, irq, ack, send, p_rts, p_txd;
	logic [7:0] adr;
	logic [31:0] dat, rdat, q;
	logic [12:0] ev [3] = '{13'h0020, 13'h0010, 13'h0011};
	lead_pkg::lead_in_s lin, lb;
	lead_pkg::lead_out_s lo;
	int n_errors, checks, cyc_n, n;
	always_comb begin
		lb = lin;
		lb.rts = p_rts;
		lb.txd = p_txd;
	end
	dte_lead_supervisor #(.FLASH_CYCLES(4), .STREAM_SCALE(SC)) dut (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_leads(lb), .o_leads(lo), .o_irq(irq));
	dte_term dte (.i_clk(clk), .i_send(send), .i_cts(lo.cts), .o_rts(p_rts), .o_txd(p_txd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 100000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Held until ack is seen high; one idle cycle after
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		{cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		r = rdat;
		{cyc, stb} <= 2'h0;
		@(posedge clk);
	endtask
	initial begin
		rst = 1'b1;
		{cyc, stb, we, send, adr, dat} = '0;
		lin = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(1'b0, lead_pkg::OFF_CTRL, 32'h0000_0000, q);
		chk(q, lead_pkg::CTRL_RESET);
		wb(1'b0, 8'h20, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		wb(1'b1, lead_pkg::OFF_IRQ_MASK, 32'h0000_0009, q);
		// Ready, carrier, no signal, service code, provider test; rxd at zero
		lin <= 13'h09C2;
		repeat (5) @(posedge clk);
		chk(lo.carrier_indicator, 1'b1);
		chk(lo.dtr_ind, 1'b1);
		chk(lo.no_signal_indicator, 1'b1);
		chk(lo.out_of_service_indicator, 1'b1);
		chk({lo.txd_ind, lo.rxd_ind}, 2'h2);
		chk(irq, 1'b1);
		wb(1'b1, lead_pkg::OFF_IRQ_STAT, 32'h0000_0008, q);
		chk(irq, 1'b0);
		for (int i = 0; i < 4; i++) begin
			lin <= 13'h0001 << i;
			repeat (5) @(posedge clk);
			chk(lo.test_active_indicator, 1'b1);
			chk(lo.carrier_indicator, 1'b0);
		end
		$display("indicator test done");
		// Line error, pattern error outside a test, pattern error in a test
		for (int i = 0; i < 3; i++) begin
			lin <= ev[i];
			@(posedge clk);
			lin <= ev[i] & 13'h0001;
			repeat (5) @(posedge clk);
			chk(lo.receive_error_indicator, i != 1);
			repeat (30) @(posedge clk);
		end
		$display("error test done");
		wb(1'b1, lead_pkg::OFF_CTRL, 32'h0000_0071, q);
		send <= 1'b1;
		n = 0;
		while (lo.cts !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk(n >= D + 3 && n <= D + 7, 1'b1);
		chk(lo.cts_ind, 1'b1);
		while (lo.cts === 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk(n >= S + 2 && n <= S + 8, 1'b1);
		chk(irq, 1'b1);
		wb(1'b0, lead_pkg::OFF_STAT, 32'h0000_0000, q);
		chk(q[2:0], 3'h2);
		chk(q[3], 1'b1);
		repeat (20) @(posedge clk);
		chk(lo.cts, 1'b0);
		send <= 1'b0;
		repeat (10) @(posedge clk);
		wb(1'b0, lead_pkg::OFF_STAT, 32'h0000_0000, q);
		chk(q[1:0], 2'h0);
		$display("stream test done");
		wb(1'b1, lead_pkg::OFF_CTRL, 32'h0000_0072, q);
		send <= 1'b1;
		repeat (D + 20) @(posedge clk);
		chk(lo.cts, 1'b0);
		send <= 1'b0;
		$display("extended test done");
		summarize();
	end
endmodule
`default_nettype wire
